// *** src/dlpc_button.sv ***
`timescale 1ns/1ns
module dlpc_button
    import dlpc_pkg::*;
#(
    parameter int unsigned SLOW_MIN = SLOW_MIN_CYC,
    parameter int unsigned FAST_MIN = FAST_MIN_CYC,
    parameter int unsigned HOLD = HOLD_CYC,
    parameter int unsigned REPEAT = REPEAT_CYC,
    parameter bit REPEAT_EN = 1'b1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Synchronised button level, low while pressed
    input wire logic press_n,
    // Timing controls
    input wire logic live,
    input wire logic slow_mode,
    // Step request
    output logic step
);

    dlpc_btn_e state_reg;
    logic [CNT_W-1:0] hold_cnt_reg;
    logic [CNT_W-1:0] rep_cnt_reg;
    logic [CNT_W-1:0] min_lim;

    assign min_lim = slow_mode ? CNT_W'(SLOW_MIN) : CNT_W'(FAST_MIN);

    // ------------------------------------------------------------
    // Press qualification and hold-to-repeat
    // ------------------------------------------------------------
    // Any bounce back high during qualification drops the press, so
    // a closure must be stable for longer than the minimum width.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg <= BTN_IDLE;
            hold_cnt_reg <= '0;
            rep_cnt_reg <= '0;
            step <= 1'b0;
        end else begin
            step <= 1'b0;
            case (state_reg)
                BTN_IDLE: begin
                    hold_cnt_reg <= '0;
                    rep_cnt_reg <= '0;
                    if (live && !press_n) begin // [RULE_09]
                        state_reg <= BTN_QUAL;
                    end
                end
                BTN_QUAL: begin
                    if (press_n) begin
                        state_reg <= BTN_IDLE;
                    end else if (hold_cnt_reg == min_lim) begin // [RULE_11]
                        step <= 1'b1; // [RULE_09]
                        state_reg <= BTN_HELD;
                    end else begin
                        hold_cnt_reg <= hold_cnt_reg + 1'b1;
                    end
                end
                BTN_HELD: begin
                    if (press_n) begin
                        state_reg <= BTN_IDLE;
                    end else if (hold_cnt_reg < CNT_W'(HOLD)) begin
                        hold_cnt_reg <= hold_cnt_reg + 1'b1;
                    end else if (REPEAT_EN) begin
                        if (rep_cnt_reg == CNT_W'(REPEAT - 1)) begin // [RULE_13]
                            step <= 1'b1;
                            rep_cnt_reg <= '0;
                        end else begin
                            rep_cnt_reg <= rep_cnt_reg + 1'b1;
                        end
                    end
                end
                default: state_reg <= BTN_IDLE;
            endcase
        end
    end

    chk_step_single: // [RULE_09]
    assert property (@(posedge ref_clk) disable iff (rst)
        step |=> !step)
    else $error("Step pulse lasted more than one cycle.");

    chk_step_live: // [RULE_25]
    assert property (@(posedge ref_clk) disable iff (rst)
        (!live && state_reg == BTN_IDLE) |=> !step)
    else $error("Step issued from an idle button before start-up.");

endmodule

// *** src/dlpc_control.sv ***
`timescale 1ns/1ns
// What this block does
// RULE_01 - A session opens when the port enable rises; activity is ignored while low.
// RULE_02 - While open, serial data is sampled on each serial clock rising edge.
// RULE_03 - A 16-bit shift register: low byte pot 0, high byte pot 1.
// RULE_04 - Bits 0-6 set pot 0 position; bit 7 mutes pot 0.
// RULE_05 - Bits 8-14 set pot 1 position; bit 15 mutes pot 1.
// RULE_06 - Host shifts least significant bit first, pot 0 byte before pot 1.
// RULE_07 - Host clocks all 16 bits before closing the session.
// RULE_08 - On enable fall, the shift register loads both wiper settings at once.
// RULE_09 - Each qualified button pulse moves that wiper exactly one position.
// RULE_10 - Attenuate steps toward the low end, gain toward the high end; code steps attenuate up toward 127 and gain down toward 0.
// RULE_11 - Single pulse lasts over 1 ms slow, over 50 us fast, to 0.8 s.
// RULE_12 - Button source spaces pulses by 1 ms slow or 50 us fast.
// RULE_13 - Held past 0.8 s, the wiper steps again every 25 ms.
// RULE_14 - Debounce mode pin is latched at power-up; high slow, low fast.
// RULE_15 - Gated serial changes wait for zero crossing or 50 ms after close.
// RULE_16 - Gate pin low enables gating; high applies changes at once.
// RULE_17 - With gating on, each button step waits for crossing or 50 ms.
// RULE_18 - Each mute activation toggles both wipers to 128 and back.
// RULE_19 - Any step button activation cancels an active hardware mute.
// RULE_20 - Host leaves software mute by rewriting the frame with mute bits clear.
// RULE_21 - The bit shifted out appears on the cascade output within 50 ns.
// RULE_22 - A chain of N devices takes 16 times N bits per session.
// RULE_23 - Readback shows bit 0 at session open; unchanged data reloads on close.
// RULE_24 - Both wiper settings start at position 127 after power-up.
// RULE_25 - Buttons and mute are ignored for 50 ms after power-up.
// RULE_26 - Host keeps the port enable high throughout any serial transfer.
// RULE_27 - Button steps saturate at positions 0 and 127, never wrapping.
// RULE_28 - Button timing runs from the internal clock, not the serial clock.
module dlpc_control
    import dlpc_pkg::*;
#(
    parameter int unsigned ZC_WAIT = ZC_WAIT_CYC,
    parameter int unsigned STARTUP = STARTUP_CYC,
    parameter int unsigned SLOW_MIN = SLOW_MIN_CYC,
    parameter int unsigned FAST_MIN = FAST_MIN_CYC,
    parameter int unsigned HOLD = HOLD_CYC,
    parameter int unsigned REPEAT = REPEAT_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Three-wire serial port
    input wire logic serial_rst_n,
    input wire logic serial_clk,
    input wire logic serial_din,
    output logic chain_serial_out,
    // Push buttons, low while pressed
    input wire logic pot0_attenuate_button,
    input wire logic pot0_gain_button,
    input wire logic pot1_attenuate_button,
    input wire logic pot1_gain_button,
    input wire logic hw_mute_button,
    // Straps and zero-crossing detection
    input wire logic debounce_slow_mode,
    input wire logic zero_cross_gate_n,
    input wire logic pot0_zero_cross,
    input wire logic pot1_zero_cross,
    // Wiper positions, 0 to 127, 128 is mute
    output logic [7:0] pot0_position,
    output logic [7:0] pot1_position
);

    localparam int CASC_MAX = 2;

    logic [PIN_COUNT-1:0] pins;
    logic [PIN_COUNT-1:0] sync1_reg;
    logic [PIN_COUNT-1:0] sync2_reg;
    logic sclk_prev_reg;
    logic sclk_rise;
    logic sess;
    logic sdin;
    logic gate_on;

    dlpc_port_e port_state_reg;
    logic [SHIFT_W-1:0] shift_reg;
    logic serial_load;

    logic slow_mode_reg;
    logic mode_done_reg;
    logic [CNT_W-1:0] startup_cnt_reg;
    logic live_reg;
    logic [NUM_BTN-1:0] btn_step;
    logic hw_mute_reg;

    dlpc_setting_s target_reg [NUM_POT];
    dlpc_setting_s applied_reg [NUM_POT];
    logic pending_reg [NUM_POT];
    logic [CNT_W-1:0] zc_timer_reg [NUM_POT];
    logic [7:0] position_reg [NUM_POT];

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    assign pins = {pot1_zero_cross, pot0_zero_cross, zero_cross_gate_n,
                   debounce_slow_mode, hw_mute_button, pot1_gain_button,
                   pot1_attenuate_button, pot0_gain_button,
                   pot0_attenuate_button, serial_din, serial_clk,
                   serial_rst_n};

    // The synchronisers run through reset, so the mode strap already
    // stands in the second stage at the first edge after release.
    always_ff @(posedge ref_clk) begin
        sync1_reg <= pins;
        sync2_reg <= sync1_reg;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sclk_prev_reg <= 1'b0;
        end else begin
            sclk_prev_reg <= sync2_reg[PIN_SCLK];
        end
    end

    // The serial clock is a pin, so its edges are found after two
    // flops; this keeps the whole block on one clock.
    assign sclk_rise = sync2_reg[PIN_SCLK] && !sclk_prev_reg; // [RULE_02]
    assign sess = sync2_reg[PIN_SRST];
    assign sdin = sync2_reg[PIN_SDIN];
    assign gate_on = !sync2_reg[PIN_ZCG_N]; // [RULE_16]

    // ------------------------------------------------------------
    // Serial port and cascade output
    // ------------------------------------------------------------
    assign serial_load = (port_state_reg == PORT_OPEN) && !sess; // [RULE_08]

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            port_state_reg <= PORT_IDLE;
            shift_reg <= SHIFT_RESET;
            chain_serial_out <= 1'b0;
        end else begin
            case (port_state_reg)
                PORT_IDLE: begin
                    if (sess) begin // [RULE_01]
                        port_state_reg <= PORT_OPEN;
                        // Current settings go out first, bit 0 at once.
                        shift_reg <= {target_reg[1], target_reg[0]}; // [RULE_23]
                        chain_serial_out <= target_reg[0].pos[0]; // [RULE_23]
                    end
                end
                PORT_OPEN: begin
                    if (!sess) begin
                        port_state_reg <= PORT_IDLE;
                    end else if (sclk_rise) begin
                        shift_reg <= {sdin, shift_reg[SHIFT_W-1:1]}; // [RULE_03]
                        chain_serial_out <= shift_reg[1]; // [RULE_21]
                    end
                end
                default: port_state_reg <= PORT_IDLE;
            endcase
        end
    end

    chk_shift_in: // [RULE_02]
    assert property (@(posedge ref_clk) disable iff (rst)
        (port_state_reg == PORT_OPEN && sess && sclk_rise) |=>
        shift_reg == {$past(sdin), $past(shift_reg[SHIFT_W-1:1])})
    else $error("Serial bit not shifted in on clock edge.");

    chk_idle_ignored: // [RULE_01]
    assert property (@(posedge ref_clk) disable iff (rst)
        (port_state_reg == PORT_IDLE && !sess) |=> $stable(shift_reg))
    else $error("Shift register moved with the port closed.");

    chk_cascade_bit: // [RULE_21]
    assert property (@(posedge ref_clk) disable iff (rst)
        (port_state_reg == PORT_OPEN && sess && sclk_rise) |->
        ##[1:CASC_MAX] chain_serial_out == shift_reg[0])
    else $error("Cascade output lags the shifted bit.");

    chk_readback_open: // [RULE_23]
    assert property (@(posedge ref_clk) disable iff (rst)
        (port_state_reg == PORT_IDLE && sess) |=>
        (shift_reg == {$past(target_reg[1]), $past(target_reg[0])}
         && chain_serial_out == shift_reg[0]))
    else $error("Session open did not present current settings.");

    // ------------------------------------------------------------
    // Power-up strap and start-up hold-off
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            slow_mode_reg <= 1'b0;
            mode_done_reg <= 1'b0;
        end else if (!mode_done_reg) begin
            slow_mode_reg <= sync2_reg[PIN_MODE]; // [RULE_14]
            mode_done_reg <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            startup_cnt_reg <= '0;
            live_reg <= 1'b0;
        end else if (!live_reg) begin
            if (startup_cnt_reg == CNT_W'(STARTUP - 1)) begin // [RULE_25]
                live_reg <= 1'b1;
            end else begin
                startup_cnt_reg <= startup_cnt_reg + 1'b1;
            end
        end
    end

    chk_mode_held: // [RULE_14]
    assert property (@(posedge ref_clk) disable iff (rst)
        mode_done_reg |=> $stable(slow_mode_reg))
    else $error("Debounce mode changed after power-up.");

    chk_startup_quiet: // [RULE_25]
    assert property (@(posedge ref_clk) disable iff (rst)
        !live_reg |-> (btn_step == '0))
    else $error("Button step before start-up hold-off ended.");

    // ------------------------------------------------------------
    // Buttons and hardware mute
    // ------------------------------------------------------------
    for (genvar b = 0; b < NUM_BTN; b++) begin : g_btn
        dlpc_button #(
            .SLOW_MIN(SLOW_MIN),
            .FAST_MIN(FAST_MIN),
            .HOLD(HOLD),
            .REPEAT(REPEAT),
            .REPEAT_EN(b != BTN_MUTE)
        ) u_btn (
            .ref_clk(ref_clk),
            .rst(rst),
            .press_n(sync2_reg[PIN_BTN + b]),
            .live(live_reg),
            .slow_mode(slow_mode_reg),
            .step(btn_step[b])
        );
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hw_mute_reg <= 1'b0;
        end else if (btn_step[NUM_BTN-2:0] != '0) begin
            hw_mute_reg <= 1'b0; // [RULE_19]
        end else if (btn_step[BTN_MUTE]) begin
            hw_mute_reg <= !hw_mute_reg; // [RULE_18]
        end
    end

    chk_mute_toggle: // [RULE_18]
    assert property (@(posedge ref_clk) disable iff (rst)
        (btn_step == NUM_BTN'(1 << BTN_MUTE)) |=>
        hw_mute_reg != $past(hw_mute_reg) ##1
        (pot0_position == MUTE_POSITION) == hw_mute_reg
        || applied_reg[0].mute)
    else $error("Hardware mute did not toggle the wipers.");

    // ------------------------------------------------------------
    // Per-potentiometer setting, gating and position
    // ------------------------------------------------------------
    for (genvar i = 0; i < NUM_POT; i++) begin : g_pot
        logic atn;
        logic gan;
        logic apply_now;

        assign atn = btn_step[2*i];
        assign gan = btn_step[2*i+1];
        assign apply_now = !gate_on || sync2_reg[PIN_ZC + i]
            || zc_timer_reg[i] == CNT_W'(ZC_WAIT - 1); // [RULE_15]

        // A step that arrives while one is waiting keeps the running
        // window, so held repeats cannot starve without crossings.
        always_ff @(posedge ref_clk) begin
            if (rst) begin
                target_reg[i] <= SETTING_RESET; // [RULE_24]
                pending_reg[i] <= 1'b0;
                zc_timer_reg[i] <= '0;
            end else if (serial_load) begin
                target_reg[i] <= shift_reg[8*i +: 8]; // [RULE_08]
                pending_reg[i] <= 1'b1;
                zc_timer_reg[i] <= '0; // [RULE_15]
            end else if (atn || gan) begin
                if (atn) begin
                    target_reg[i].pos <= (target_reg[i].pos == POS_MAX) ?
                        POS_MAX : target_reg[i].pos + 7'h01; // [RULE_10] [RULE_27]
                end else begin
                    target_reg[i].pos <= (target_reg[i].pos == POS_MIN) ?
                        POS_MIN : target_reg[i].pos - 7'h01; // [RULE_10] [RULE_27]
                end
                pending_reg[i] <= 1'b1; // [RULE_17]
                if (!pending_reg[i]) begin
                    zc_timer_reg[i] <= '0;
                end
            end else if (pending_reg[i]) begin
                if (apply_now) begin
                    pending_reg[i] <= 1'b0;
                    zc_timer_reg[i] <= '0;
                end else begin
                    zc_timer_reg[i] <= zc_timer_reg[i] + 1'b1;
                end
            end
        end

        always_ff @(posedge ref_clk) begin
            if (rst) begin
                applied_reg[i] <= SETTING_RESET; // [RULE_24]
            end else if (pending_reg[i] && apply_now) begin
                applied_reg[i] <= target_reg[i]; // [RULE_16] [RULE_17]
            end
        end

        always_ff @(posedge ref_clk) begin
            if (rst) begin
                position_reg[i] <= {1'b0, POS_MAX};
            end else if (hw_mute_reg || applied_reg[i].mute) begin
                position_reg[i] <= MUTE_POSITION; // [RULE_04] [RULE_05]
            end else begin
                position_reg[i] <= {1'b0, applied_reg[i].pos};
            end
        end

        chk_ungated_apply: // [RULE_16]
        assert property (@(posedge ref_clk) disable iff (rst)
            (pending_reg[i] && !gate_on && !serial_load && !atn && !gan)
            |=> !pending_reg[i] && applied_reg[i] == $past(target_reg[i]))
        else $error("Ungated change was not applied at once.");

        chk_zc_timeout: // [RULE_15]
        assert property (@(posedge ref_clk) disable iff (rst)
            (pending_reg[i] && zc_timer_reg[i] == CNT_W'(ZC_WAIT - 1)
             && !serial_load && !atn && !gan) |=> !pending_reg[i])
        else $error("Zero-crossing window did not time out.");

        chk_soft_mute: // [RULE_04]
        assert property (@(posedge ref_clk) disable iff (rst)
            applied_reg[i].mute |=> position_reg[i] == MUTE_POSITION)
        else $error("Software mute bit did not force mute position.");

        chk_saturate_low: // [RULE_27]
        assert property (@(posedge ref_clk) disable iff (rst)
            (gan && !atn && !serial_load && target_reg[i].pos == POS_MIN)
            |=> target_reg[i].pos == POS_MIN)
        else $error("Gain step wrapped below position zero.");
    end

    assign pot0_position = position_reg[0];
    assign pot1_position = position_reg[1];

endmodule

// *** src/dlpc_pkg.sv ***
package dlpc_pkg;

    // ------------------------------------------------------------
    // Clock and times
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int CLK_NS = 10;
    localparam int SLOW_MIN_US = 1000;
    localparam int FAST_MIN_US = 50;
    localparam int HOLD_MS = 800;
    localparam int REPEAT_MS = 25;
    localparam int ZC_WINDOW_MS = 50;
    localparam int STARTUP_MS = 50;
    localparam int CASCADE_NS = 50;

    localparam int SLOW_MIN_CYC = SLOW_MIN_US * CLK_MHZ;
    localparam int FAST_MIN_CYC = FAST_MIN_US * CLK_MHZ;
    localparam int HOLD_CYC = HOLD_MS * 1000 * CLK_MHZ;
    localparam int REPEAT_CYC = REPEAT_MS * 1000 * CLK_MHZ;
    localparam int ZC_WAIT_CYC = ZC_WINDOW_MS * 1000 * CLK_MHZ;
    localparam int STARTUP_CYC = STARTUP_MS * 1000 * CLK_MHZ;
    localparam int CASCADE_CYC = CASCADE_NS / CLK_NS;

    // ------------------------------------------------------------
    // Widths, positions and reset values
    // ------------------------------------------------------------
    localparam int SHIFT_W = 16;
    localparam int CNT_W = 27;
    localparam int NUM_POT = 2;
    localparam int NUM_BTN = 5;
    localparam int BTN_MUTE = 4;
    localparam logic [6:0] POS_MIN = 7'h00;
    localparam logic [6:0] POS_MAX = 7'h7F;
    localparam logic [7:0] MUTE_POSITION = 8'h80;

    // Index of each pin in the synchroniser vector.
    localparam int PIN_SRST = 0;
    localparam int PIN_SCLK = 1;
    localparam int PIN_SDIN = 2;
    localparam int PIN_BTN = 3;
    localparam int PIN_MODE = 8;
    localparam int PIN_ZCG_N = 9;
    localparam int PIN_ZC = 10;
    localparam int PIN_COUNT = 12;

    typedef struct packed {
        logic mute;
        logic [6:0] pos;
    } dlpc_setting_s;

    localparam dlpc_setting_s SETTING_RESET = '{mute: 1'b0, pos: 7'h7F};
    localparam logic [15:0] SHIFT_RESET = 16'h7F7F;

    typedef enum {PORT_IDLE, PORT_OPEN} dlpc_port_e;
    typedef enum {BTN_IDLE, BTN_QUAL, BTN_HELD} dlpc_btn_e;

endpackage

// *** verification/dlpc_host.sv ***
`timescale 1ns/1ns
module dlpc_host (
    // Serial pins toward the device
    output logic serial_rst_n,
    output logic serial_clk,
    output logic serial_din,
    // Cascade data back from the device
    input wire logic chain_serial_out
);
    initial begin
        serial_rst_n = 1'b0;
        serial_clk = 1'b0;
        serial_din = 1'b0;
    end

    // ----------------------------------------
    // Frames
    // ----------------------------------------
    // Between frames the serial clock only moves when stray pulses it.
    task automatic frame(input logic [15:0] w, output logic [15:0] rd);
        // Frames start on a bench clock edge; this offset keeps every
        // pin edge of the frame clear of the sampling edges.
        #4;
        serial_rst_n = 1'b1;
        #63;
        for (int i = 0; i < 16; i++) begin
            serial_din = w[i];
            #31;
            rd[i] = chain_serial_out;
            serial_clk = 1'b1;
            #63;
            serial_clk = 1'b0;
            #31;
        end
        #31;
        serial_rst_n = 1'b0;
        // A released data line must not keep looking like the last bit.
        serial_din = ~serial_din;
    endtask

    // Clock pulses with the port closed.
    task automatic stray(input int n);
        repeat (n) begin
            serial_din = ~serial_din;
            #62 serial_clk = 1'b1;
            #63 serial_clk = 1'b0;
        end
    endtask
endmodule

// *** verification/test_dlpc_control.sv ***
`timescale 1ns/1ns
module test_dlpc_control;
    import dlpc_pkg::*;
    localparam int ZW = 50;
    logic ref_clk, rst, serial_rst_n, serial_clk, serial_din;
    logic chain_serial_out, slow, zcg_n, zc0, zc1, known;
    logic [4:0] btn_n;
    logic [7:0] pos0, pos1;
    logic [15:0] cur, rd, w;
    logic [31:0] seed;
    int n_errors, checks;

    dlpc_control #(.ZC_WAIT(ZW), .STARTUP(20), .SLOW_MIN(10),
        .FAST_MIN(5), .HOLD(100), .REPEAT(8)) u_dlpc_control (
        .ref_clk(ref_clk), .rst(rst), .serial_rst_n(serial_rst_n),
        .serial_clk(serial_clk), .serial_din(serial_din),
        .chain_serial_out(chain_serial_out),
        .pot0_attenuate_button(btn_n[0]), .pot0_gain_button(btn_n[1]),
        .pot1_attenuate_button(btn_n[2]), .pot1_gain_button(btn_n[3]),
        .hw_mute_button(btn_n[4]), .debounce_slow_mode(slow),
        .zero_cross_gate_n(zcg_n), .pot0_zero_cross(zc0),
        .pot1_zero_cross(zc1), .pot0_position(pos0), .pot1_position(pos1));

    dlpc_host u_dlpc_host (.serial_rst_n(serial_rst_n),
        .serial_clk(serial_clk), .serial_din(serial_din),
        .chain_serial_out(chain_serial_out));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    function automatic logic [7:0] exp_pos(input logic [7:0] b);
        return b[7] ? MUTE_POSITION : {1'b0, b[6:0]};
    endfunction

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic pots(input logic [7:0] e0, input logic [7:0] e1);
        check({8'h00, pos0}, {8'h00, e0});
        check({8'h00, pos1}, {8'h00, e1});
    endtask

    // Readback of the previous settings is compared on every frame written while known is set.
    task automatic write(input logic [15:0] v);
        u_dlpc_host.frame(v, rd);
        repeat (8) @(posedge ref_clk);
        if (known) check(rd, cur);
        known = 1'b1;
        cur = v;
    endtask

    task automatic press(input int b, input int n);
        @(posedge ref_clk);
        btn_n[b] <= 1'b0;
        repeat (n) @(posedge ref_clk);
        btn_n[b] <= 1'b1;
        repeat (20) @(posedge ref_clk);
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial begin
        #500000;
        $display("ERROR %0t run did not finish", $time);
        n_errors++;
        final_report();
    end

    initial begin
        rst = 1'b1;
        btn_n = 5'h1F;
        slow = 1'b0;
        zcg_n = 1'b1;
        zc0 = 1'b0;
        zc1 = 1'b0;
        seed = 32'h3F75;
        cur = 16'h7F7F;
        known = 1'b1;
        n_errors = 0;
        checks = 0;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        pots(8'h7F, 8'h7F);
        press(1, 12);
        pots(8'h7F, 8'h7F);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            w = seed[15:0];
            write(w);
            pots(exp_pos(w[7:0]), exp_pos(w[15:8]));
        end
        u_dlpc_host.stray(4);
        repeat (8) @(posedge ref_clk);
        pots(exp_pos(w[7:0]), exp_pos(w[15:8]));
        write(16'h4040);
        press(0, 15);
        press(3, 15);
        pots(8'h41, 8'h3F);
        cur = 16'h3F41;
        write(16'h007F);
        press(0, 15);
        press(3, 15);
        pots(8'h7F, 8'h00);
        press(1, 132);
        check({15'h0, pos0 >= 8'h78 && pos0 <= 8'h7C}, 16'h1);
        known = 1'b0;
        write(16'h8080);
        pots(8'h80, 8'h80);
        write(16'h3050);
        press(4, 15);
        pots(8'h80, 8'h80);
        press(4, 15);
        pots(8'h50, 8'h30);
        press(4, 15);
        press(2, 15);
        pots(8'h50, 8'h31);
        zcg_n <= 1'b0;
        cur = 16'h3150;
        write(16'h2010);
        pots(8'h50, 8'h31);
        zc0 <= 1'b1;
        repeat (3) @(posedge ref_clk);
        zc0 <= 1'b0;
        repeat (8) @(posedge ref_clk);
        pots(8'h10, 8'h31);
        repeat (ZW) @(posedge ref_clk);
        pots(8'h10, 8'h20);
        press(2, 15);
        pots(8'h10, 8'h20);
        zc1 <= 1'b1;
        repeat (3) @(posedge ref_clk);
        zc1 <= 1'b0;
        repeat (8) @(posedge ref_clk);
        pots(8'h10, 8'h21);
        // Second reset with the strap high: slow debounce from here on.
        slow <= 1'b1;
        rst <= 1'b1;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        pots(8'h7F, 8'h7F);
        repeat (30) @(posedge ref_clk);
        press(1, 8);
        repeat (ZW) @(posedge ref_clk);
        pots(8'h7F, 8'h7F);
        press(1, 15);
        repeat (ZW) @(posedge ref_clk);
        pots(8'h7E, 8'h7F);
        final_report();
    end
endmodule
